// ---- common/pin_mux_defs.vh ----
// Constants of the pad function selector: offsets, fields, pads, idle levels
// Behaviour
// - Select b 7:6 on pad ten: gpio, infrared mode, infrared rx3, reserved
// - Select b 5:4 on pad six: gpio, infrared mode, infrared rx3, reserved
// - Select b bit 3 chooses plain output eleven or pulse width output one
// - DMA three select puts request on output nine, acknowledge on gpio 19
// - Output eight pad: DMA two request, else CPU reset or output eight
// - Scan twelve pad: scan output, else CPU reset or plain output eight
// - Select b bit 0 turns gpio four and five into scan outputs 14, 15
// - Select c bit 7 makes gpio seven open-drain; zero means push-pull
// - Pad five: floppy select one, else output five or keyboard reset
// - Select c bit 5 makes output zero push-pull; zero means open-drain
// - Select c bit 4 puts second two-wire data and clock on gpio 11, 12
// - Both selects are 8-bit, controller-only read/write, reset to 0x00
// - Gate/reset select bit puts address line 20 gate on gpio seventeen
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SEL_C_ADDR          16'h7F30
`define SEL_B_ADDR          16'h7F40
`define SEL_RESET           8'h00

// ----------------------------------------------------------------------------
// Fields of select b
// ----------------------------------------------------------------------------
`define B_GPIO_TEN_HI       7
`define B_GPIO_TEN_LO       6
`define B_GPIO_SIX_HI       5
`define B_GPIO_SIX_LO       4
`define B_PWM_ONE           3
`define B_DMA_THREE         2
`define B_DMA_TWO           1
`define B_EXTRA_SCAN        0

// ----------------------------------------------------------------------------
// Fields of select c
// ----------------------------------------------------------------------------
`define C_GP_SEVEN_DRIVE    7
`define C_KBD_RESET         6
`define C_OUT_ZERO_DRIVE    5
`define C_SECOND_TWOWIRE    4
`define C_SCAN_TWELVE       1

// ----------------------------------------------------------------------------
// Pad vector positions: general pins 0..8, output-only pads 9..14
// ----------------------------------------------------------------------------
`define NUM_GPIO_PADS       9
`define NUM_PADS            15
`define PAD_GPIO_TEN        0
`define PAD_GPIO_SIX        1
`define PAD_GPIO_NINETEEN   2
`define PAD_GPIO_FOUR       3
`define PAD_GPIO_FIVE       4
`define PAD_GPIO_SEVEN      5
`define PAD_GPIO_ELEVEN     6
`define PAD_GPIO_TWELVE     7
`define PAD_GPIO_SEVENTEEN  8
`define PAD_OUT_ELEVEN      9
`define PAD_OUT_NINE        10
`define PAD_OUT_EIGHT       11
`define PAD_SCAN_TWELVE     12
`define PAD_OUT_FIVE        13
`define PAD_OUT_ZERO        14

// ----------------------------------------------------------------------------
// Levels shown to a deselected function
// ----------------------------------------------------------------------------
`define IDLE_GPIO_IN        1'b0
`define IDLE_IR_RX          1'b1
`define IDLE_DMA_ACK_N      1'b1
`define IDLE_TWOWIRE_IN     1'b1

`endif

// ---- logic/pad_driver.v ----
// One registered pad driver with optional open-drain behaviour
`timescale 1ns/1ps
module pad_driver (
  input  wire i_mclk,
  input  wire i_reset_n,
  input  wire i_out,
  input  wire i_oe_n,
  input  wire i_open_drain,
  output reg  o_out,
  output reg  o_oe_n
);

  // ----------------------------------------------------------------------
  // Open drain only ever pulls low; a high value releases the pad
  // ----------------------------------------------------------------------
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out  <= 1'b0;
      o_oe_n <= 1'b1;
    end else begin
      o_out  <= i_out;
      o_oe_n <= i_oe_n | (i_open_drain & i_out);
    end
  end

endmodule // pad_driver

// ---- logic/pin_function_mux.v ----
// Pad function selector with its two controller-side select registers
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module pin_function_mux (
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // Embedded controller register port
  input  wire [15:0] i_ec_addr,
  input  wire        i_ec_wr,
  input  wire        i_ec_rd,
  input  wire [7:0]  i_ec_wdata,
  output reg  [7:0]  o_ec_rdata,
  // Selects held in the first select register
  input  wire        i_gate_reset_select,
  input  wire        i_floppy_one_select,
  // General purpose block, pads 0..8
  input  wire [8:0]  i_gpio_out,
  input  wire [8:0]  i_gpio_oe_n,
  output reg  [8:0]  o_gpio_in,
  // Pads
  input  wire [8:0]  i_pad_in,
  output wire [14:0] o_pad_out,
  output wire [14:0] o_pad_oe_n,
  // Alternate function sources
  input  wire        i_infrared_mode_out,
  input  wire        i_pulse_width_out_one,
  input  wire        i_dma_two_req,
  input  wire        i_dma_three_req,
  input  wire        i_cpu_reset,
  input  wire        i_keyboard_reset_out,
  input  wire        i_floppy_drive_select_one,
  input  wire        i_address_line20_gate,
  input  wire        i_scan_drive_twelve,
  input  wire        i_scan_drive_fourteen,
  input  wire        i_scan_drive_fifteen,
  input  wire        i_plain_output_eleven,
  input  wire        i_plain_output_nine,
  input  wire        i_plain_output_eight,
  input  wire        i_plain_output_five,
  input  wire        i_plain_output_zero,
  input  wire        i_twowire_data_out,
  input  wire        i_twowire_data_oe_n,
  input  wire        i_twowire_clk_out,
  input  wire        i_twowire_clk_oe_n,
  // Alternate function inputs
  output reg         o_infrared_rx_three,
  output reg         o_dma_three_ack_n,
  output reg         o_twowire_data_in,
  output reg         o_twowire_clk_in
);

  // ----------------------------------------------------------------------
  // Select registers
  // ----------------------------------------------------------------------
  reg  [7:0]  sel_b_q;
  reg  [7:0]  sel_c_q;
  reg  [8:0]  pad_s1_q;
  reg  [8:0]  pad_s2_q;
  reg  [14:0] pad_out_d;
  reg  [14:0] pad_oe_n_d;
  reg  [14:0] pad_od_d;
  reg  [8:0]  gpio_in_d;
  reg         irrx_d;
  reg         dack_n_d;
  reg         tw_data_d;
  reg         tw_clk_d;

  wire [1:0]  ten_sel          = {sel_b_q[`B_GPIO_TEN_HI],
                                  sel_b_q[`B_GPIO_TEN_LO]};
  wire [1:0]  six_sel          = {sel_b_q[`B_GPIO_SIX_HI],
                                  sel_b_q[`B_GPIO_SIX_LO]};
  wire        pwm_one_select   = sel_b_q[`B_PWM_ONE];
  wire        dma_three_select = sel_b_q[`B_DMA_THREE];
  wire        dma_two_select   = sel_b_q[`B_DMA_TWO];
  wire        extra_scan_select = sel_b_q[`B_EXTRA_SCAN];
  wire        gp_seven_od      = sel_c_q[`C_GP_SEVEN_DRIVE];
  wire        kbd_reset_select = sel_c_q[`C_KBD_RESET];
  wire        out_zero_pp      = sel_c_q[`C_OUT_ZERO_DRIVE];
  wire        twowire_select   = sel_c_q[`C_SECOND_TWOWIRE];
  wire        scan_twelve_select = sel_c_q[`C_SCAN_TWELVE];

  // Controller-only access; no host path exists into these registers
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_b_q    <= `SEL_RESET;
      sel_c_q    <= `SEL_RESET;
      o_ec_rdata <= 8'h00;
    end else begin
      if (i_ec_wr && (i_ec_addr == `SEL_B_ADDR)) begin
        sel_b_q <= i_ec_wdata;
      end
      if (i_ec_wr && (i_ec_addr == `SEL_C_ADDR)) begin
        sel_c_q <= i_ec_wdata;
      end
      // Unmapped reads return zero rather than stale data
      if (i_ec_rd && (i_ec_addr == `SEL_B_ADDR)) begin
        o_ec_rdata <= sel_b_q;
      end else if (i_ec_rd && (i_ec_addr == `SEL_C_ADDR)) begin
        o_ec_rdata <= sel_c_q;
      end else if (i_ec_rd) begin
        o_ec_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pad input synchroniser
  // ----------------------------------------------------------------------
  // Pads are asynchronous; two stages before any selection logic looks
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pad_s1_q <= 9'h000;
      pad_s2_q <= 9'h000;
    end else begin
      pad_s1_q <= i_pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------------
  // Default: pads 0..8 carry their general function, pads 9..14 start at zero, all push-pull
  always @* begin
    pad_out_d  = {6'h00, i_gpio_out};
    pad_oe_n_d = {6'h00, i_gpio_oe_n};
    pad_od_d   = 15'h0000;
    // Pad ten: reserved code releases the pad so nothing fights it
    case (ten_sel)
      2'b00: ;
      2'b01: begin
        pad_out_d[`PAD_GPIO_TEN]  = i_infrared_mode_out;
        pad_oe_n_d[`PAD_GPIO_TEN] = 1'b0;
      end
      default: begin
        pad_out_d[`PAD_GPIO_TEN]  = 1'b0;
        pad_oe_n_d[`PAD_GPIO_TEN] = 1'b1;
      end
    endcase
    case (six_sel)
      2'b00: ;
      2'b01: begin
        pad_out_d[`PAD_GPIO_SIX]  = i_infrared_mode_out;
        pad_oe_n_d[`PAD_GPIO_SIX] = 1'b0;
      end
      default: begin
        pad_out_d[`PAD_GPIO_SIX]  = 1'b0;
        pad_oe_n_d[`PAD_GPIO_SIX] = 1'b1;
      end
    endcase
    // Output eleven
    pad_out_d[`PAD_OUT_ELEVEN] = pwm_one_select ? i_pulse_width_out_one
                                 : i_plain_output_eleven;
    // Output nine and gpio nineteen
    pad_out_d[`PAD_OUT_NINE] = dma_three_select ? i_dma_three_req
                               : i_plain_output_nine;
    if (dma_three_select) begin
      pad_out_d[`PAD_GPIO_NINETEEN]  = 1'b0;
      pad_oe_n_d[`PAD_GPIO_NINETEEN] = 1'b1;
    end
    // Output eight: DMA request outranks the reset choice
    if (dma_two_select) begin
      pad_out_d[`PAD_OUT_EIGHT] = i_dma_two_req;
    end else if (i_gate_reset_select) begin
      pad_out_d[`PAD_OUT_EIGHT] = i_cpu_reset;
    end else begin
      pad_out_d[`PAD_OUT_EIGHT] = i_plain_output_eight;
    end
    // Scan twelve; with DMA two deselected the eight/reset choice can appear on both pads
    if (!scan_twelve_select) begin
      pad_out_d[`PAD_SCAN_TWELVE] = i_scan_drive_twelve;
    end else if (i_gate_reset_select) begin
      pad_out_d[`PAD_SCAN_TWELVE] = i_cpu_reset;
    end else begin
      pad_out_d[`PAD_SCAN_TWELVE] = i_plain_output_eight;
    end
    // Extra scan lines
    if (extra_scan_select) begin
      pad_out_d[`PAD_GPIO_FOUR]  = i_scan_drive_fourteen;
      pad_oe_n_d[`PAD_GPIO_FOUR] = 1'b0;
      pad_out_d[`PAD_GPIO_FIVE]  = i_scan_drive_fifteen;
      pad_oe_n_d[`PAD_GPIO_FIVE] = 1'b0;
    end
    pad_od_d[`PAD_GPIO_SEVEN] = gp_seven_od;
    // Output five: floppy select wins over the keyboard reset choice
    if (i_floppy_one_select) begin
      pad_out_d[`PAD_OUT_FIVE] = i_floppy_drive_select_one;
    end else if (kbd_reset_select) begin
      pad_out_d[`PAD_OUT_FIVE] = i_keyboard_reset_out;
    end else begin
      pad_out_d[`PAD_OUT_FIVE] = i_plain_output_five;
    end
    pad_out_d[`PAD_OUT_ZERO] = i_plain_output_zero;
    pad_od_d[`PAD_OUT_ZERO]  = ~out_zero_pp;
    // Two-wire function drives its own enables, already open-drain style
    if (twowire_select) begin
      pad_out_d[`PAD_GPIO_ELEVEN]  = i_twowire_data_out;
      pad_oe_n_d[`PAD_GPIO_ELEVEN] = i_twowire_data_oe_n;
      pad_out_d[`PAD_GPIO_TWELVE]  = i_twowire_clk_out;
      pad_oe_n_d[`PAD_GPIO_TWELVE] = i_twowire_clk_oe_n;
    end
    if (i_gate_reset_select) begin
      pad_out_d[`PAD_GPIO_SEVENTEEN]  = i_address_line20_gate;
      pad_oe_n_d[`PAD_GPIO_SEVENTEEN] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Input steering
  // ----------------------------------------------------------------------
  // Receive paths of deselected functions sit at their idle level
  always @* begin
    gpio_in_d = pad_s2_q;
    irrx_d    = `IDLE_IR_RX;
    dack_n_d  = `IDLE_DMA_ACK_N;
    tw_data_d = `IDLE_TWOWIRE_IN;
    tw_clk_d  = `IDLE_TWOWIRE_IN;
    if (ten_sel != 2'b00) begin
      gpio_in_d[`PAD_GPIO_TEN] = `IDLE_GPIO_IN;
    end
    if (six_sel != 2'b00) begin
      gpio_in_d[`PAD_GPIO_SIX] = `IDLE_GPIO_IN;
    end
    // Both pads may feed receive three; a low on either is seen
    if (ten_sel == 2'b10) begin
      irrx_d = irrx_d & pad_s2_q[`PAD_GPIO_TEN];
    end
    if (six_sel == 2'b10) begin
      irrx_d = irrx_d & pad_s2_q[`PAD_GPIO_SIX];
    end
    if (dma_three_select) begin
      dack_n_d = pad_s2_q[`PAD_GPIO_NINETEEN];
      gpio_in_d[`PAD_GPIO_NINETEEN] = `IDLE_GPIO_IN;
    end
    if (extra_scan_select) begin
      gpio_in_d[`PAD_GPIO_FOUR] = `IDLE_GPIO_IN;
      gpio_in_d[`PAD_GPIO_FIVE] = `IDLE_GPIO_IN;
    end
    if (twowire_select) begin
      tw_data_d = pad_s2_q[`PAD_GPIO_ELEVEN];
      tw_clk_d  = pad_s2_q[`PAD_GPIO_TWELVE];
      gpio_in_d[`PAD_GPIO_ELEVEN] = `IDLE_GPIO_IN;
      gpio_in_d[`PAD_GPIO_TWELVE] = `IDLE_GPIO_IN;
    end
    if (i_gate_reset_select) begin
      gpio_in_d[`PAD_GPIO_SEVENTEEN] = `IDLE_GPIO_IN;
    end
  end

  // Function inputs are registered so every output leaves a flip-flop
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gpio_in           <= 9'h000;
      o_infrared_rx_three <= `IDLE_IR_RX;
      o_dma_three_ack_n   <= `IDLE_DMA_ACK_N;
      o_twowire_data_in   <= `IDLE_TWOWIRE_IN;
      o_twowire_clk_in    <= `IDLE_TWOWIRE_IN;
    end else begin
      o_gpio_in           <= gpio_in_d;
      o_infrared_rx_three <= irrx_d;
      o_dma_three_ack_n   <= dack_n_d;
      o_twowire_data_in   <= tw_data_d;
      o_twowire_clk_in    <= tw_clk_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------------
  // One registered driver per pad keeps the enable and value aligned
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PADS; gi = gi + 1) begin : g_pad
      pad_driver u_drv (
        .i_mclk       (i_mclk),
        .i_reset_n    (i_reset_n),
        .i_out        (pad_out_d[gi]),
        .i_oe_n       (pad_oe_n_d[gi]),
        .i_open_drain (pad_od_d[gi]),
        .o_out        (o_pad_out[gi]),
        .o_oe_n       (o_pad_oe_n[gi])
      );
    end
  endgenerate

endmodule // pin_function_mux

// ---- tb/pin_function_mux_asserts.sv ----
// Concurrent checks on the pad function selector ports
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module pin_function_mux_asserts (
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_ec_addr,
  input wire logic        i_ec_wr,
  input wire logic        i_ec_rd,
  input wire logic [7:0]  i_ec_wdata,
  input wire logic [7:0]  o_ec_rdata,
  input wire logic        i_gate_reset_select,
  input wire logic [8:0]  i_gpio_out,
  input wire logic [14:0] o_pad_out,
  input wire logic [14:0] o_pad_oe_n,
  input wire logic        i_pulse_width_out_one,
  input wire logic        i_dma_two_req,
  input wire logic        i_dma_three_req,
  input wire logic        i_cpu_reset,
  input wire logic        i_address_line20_gate,
  input wire logic        i_scan_drive_twelve,
  input wire logic        i_plain_output_eleven,
  input wire logic        i_plain_output_nine,
  input wire logic        i_plain_output_eight,
  input wire logic        i_plain_output_zero
);
  // ------------------------------
  // Shadow selects and helpers
  // ------------------------------
  logic [7:0] b_q;
  logic [7:0] c_q;
  logic       armed_q;
  wire        cpu_or_plain_output_eight;

  // Armed stays low on the first edge, where pads still show reset levels
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      b_q     <= 8'h00;
      c_q     <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      if (i_ec_wr && i_ec_addr == `SEL_B_ADDR) b_q <= i_ec_wdata;
      if (i_ec_wr && i_ec_addr == `SEL_C_ADDR) c_q <= i_ec_wdata;
    end
  end
  assign cpu_or_plain_output_eight = i_gate_reset_select ? i_cpu_reset
                                           : i_plain_output_eight;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // ------------------------------
  // Register port
  // ------------------------------
  sequence s_wr_b;
    i_ec_wr && i_ec_addr == `SEL_B_ADDR;
  endsequence
  sequence s_rd_b;
    i_ec_rd && !i_ec_wr && i_ec_addr == `SEL_B_ADDR;
  endsequence
  a_write_then_read: assert property (
    s_wr_b ##2 s_rd_b |=> o_ec_rdata == $past(i_ec_wdata, 3))
    else $error("select b read-back differs from written byte");
  a_read_sel_c: assert property (
    i_ec_rd && i_ec_addr == `SEL_C_ADDR |=> o_ec_rdata == $past(c_q))
    else $error("select c read-back wrong");
  a_read_unmapped: assert property (
    i_ec_rd && i_ec_addr != `SEL_B_ADDR && i_ec_addr != `SEL_C_ADDR
    |=> o_ec_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ------------------------------
  // Pad routing, one cycle behind
  // ------------------------------
  a_pad_ten_release: assert property (
    armed_q && $past(b_q[7]) |-> o_pad_oe_n[0])
    else $error("pad ten driven in input or reserved code");
  a_pwm_route: assert property (
    armed_q |-> o_pad_out[9] == ($past(b_q[3]) ?
      $past(i_pulse_width_out_one) : $past(i_plain_output_eleven)))
    else $error("output eleven pad carries wrong source");
  a_dma_three_route: assert property (
    armed_q |-> (o_pad_out[10] == ($past(b_q[2]) ?
      $past(i_dma_three_req) : $past(i_plain_output_nine)))
      && (!$past(b_q[2]) || o_pad_oe_n[2]))
    else $error("channel three request or acknowledge pad wrong");
  a_out_eight_route: assert property (
    armed_q |-> o_pad_out[11] == ($past(b_q[1]) ?
      $past(i_dma_two_req) : $past(cpu_or_plain_output_eight)))
    else $error("output eight pad carries wrong source");
  a_scan_twelve_route: assert property (
    armed_q |-> o_pad_out[12] == ($past(c_q[1]) ?
      $past(cpu_or_plain_output_eight) : $past(i_scan_drive_twelve)))
    else $error("scan twelve pad carries wrong source");
  a_gp_seven_drain: assert property (
    armed_q && $past(c_q[7]) && $past(i_gpio_out[5]) |-> o_pad_oe_n[5])
    else $error("pin seven drives high while open-drain");
  a_out_zero_drive: assert property (
    armed_q |-> o_pad_oe_n[14] ==
      (!$past(c_q[5]) && $past(i_plain_output_zero)))
    else $error("output zero buffer mode wrong");
  a_gate_a20_route: assert property (
    armed_q && $past(i_gate_reset_select) |->
      o_pad_out[8] == $past(i_address_line20_gate) && !o_pad_oe_n[8])
    else $error("pin seventeen not carrying gate");
endmodule // pin_function_mux_asserts

bind pin_function_mux pin_function_mux_asserts u_asserts (
  .i_mclk, .i_reset_n, .i_ec_addr, .i_ec_wr, .i_ec_rd, .i_ec_wdata,
  .o_ec_rdata, .i_gate_reset_select, .i_gpio_out, .o_pad_out, .o_pad_oe_n,
  .i_pulse_width_out_one, .i_dma_two_req, .i_dma_three_req, .i_cpu_reset,
  .i_address_line20_gate, .i_scan_drive_twelve, .i_plain_output_eleven,
  .i_plain_output_nine, .i_plain_output_eight, .i_plain_output_zero);

// ---- tb/pin_function_mux_tb.sv ----
// Self-checking bench for the pad function selector
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module pin_function_mux_tb;
  logic        i_mclk, i_reset_n, i_ec_wr, i_ec_rd;
  logic [15:0] i_ec_addr;
  logic [7:0]  i_ec_wdata, o_ec_rdata, b, c;
  logic        i_gate_reset_select, i_floppy_one_select;
  logic [8:0]  i_gpio_out, i_gpio_oe_n, o_gpio_in, i_pad_in, gi;
  logic [14:0] o_pad_out, o_pad_oe_n, eo, ee, msk;
  logic [19:0] fn;
  logic [3:0]  fi, fo;
  int          err_total, samples_checked;

  pin_function_mux dut (.i_mclk, .i_reset_n, .i_ec_addr, .i_ec_wr, .i_ec_rd,
    .i_ec_wdata, .o_ec_rdata, .i_gate_reset_select, .i_floppy_one_select,
    .i_gpio_out, .i_gpio_oe_n, .o_gpio_in, .i_pad_in, .o_pad_out, .o_pad_oe_n,
    .i_infrared_mode_out(fn[0]), .i_pulse_width_out_one(fn[1]),
    .i_dma_two_req(fn[2]), .i_dma_three_req(fn[3]), .i_cpu_reset(fn[4]),
    .i_keyboard_reset_out(fn[5]), .i_floppy_drive_select_one(fn[6]),
    .i_address_line20_gate(fn[7]), .i_scan_drive_twelve(fn[8]),
    .i_scan_drive_fourteen(fn[9]), .i_scan_drive_fifteen(fn[10]),
    .i_plain_output_eleven(fn[11]), .i_plain_output_nine(fn[12]),
    .i_plain_output_eight(fn[13]), .i_plain_output_five(fn[14]),
    .i_plain_output_zero(fn[15]), .i_twowire_data_out(fn[16]),
    .i_twowire_data_oe_n(fn[17]), .i_twowire_clk_out(fn[18]),
    .i_twowire_clk_oe_n(fn[19]), .o_infrared_rx_three(fo[0]),
    .o_dma_three_ack_n(fo[1]), .o_twowire_data_in(fo[2]),
    .o_twowire_clk_in(fo[3]));

  // 125 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Writes hold the strobe one cycle; reads compare one cycle after
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    {i_ec_wr, i_ec_addr, i_ec_wdata} <= {1'b1, a, d};
    @(posedge i_mclk);
    i_ec_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    {i_ec_rd, i_ec_addr} <= {1'b1, a};
    @(posedge i_mclk);
    i_ec_rd <= 1'b0;
    #1;
    check({7'h0, o_ec_rdata}, {7'h0, exp});
  endtask

  // Fresh random levels on every function source and pad
  task automatic stir;
    fn <= 20'($urandom);
    i_gpio_out <= 9'($urandom);
    i_gpio_oe_n <= 9'($urandom);
    i_pad_in <= 9'($urandom);
    {i_gate_reset_select, i_floppy_one_select} <= 2'($urandom);
  endtask

  // Reference pad map; msk hides values on pads ten, six and nineteen when their selects release them
  task automatic compare;
    logic [1:0] cd;
    logic       c8;
    c8 = i_gate_reset_select ? fn[4] : fn[13];
    {eo, ee, msk} = {6'h0, i_gpio_out, 6'h0, i_gpio_oe_n, 15'h0};
    {gi, fi} = {i_pad_in, 4'hF};
    for (int p = 0; p < 2; p++) begin
      cd = b[7-2*p -: 2];
      if (cd != 2'd0) gi[p] = 1'b0;
      if (cd == 2'd1) {eo[p], ee[p]} = {fn[0], 1'b0};
      if (cd[1]) {ee[p], msk[p]} = 2'b11;
      if (cd == 2'd2) fi[0] = fi[0] & i_pad_in[p];
    end
    eo[9] = b[3] ? fn[1] : fn[11];
    eo[10] = b[2] ? fn[3] : fn[12];
    if (b[2]) {ee[2], msk[2], gi[2], fi[1]} = {3'b110, i_pad_in[2]};
    eo[11] = b[1] ? fn[2] : c8;
    eo[12] = c[1] ? c8 : fn[8];
    if (b[0]) {eo[4:3], ee[4:3], gi[4:3]} = {fn[10:9], 4'h0};
    ee[5] = i_gpio_oe_n[5] | (c[7] & i_gpio_out[5]);
    eo[13] = i_floppy_one_select ? fn[6] : (c[6] ? fn[5] : fn[14]);
    {eo[14], ee[14]} = {fn[15], !c[5] & fn[15]};
    if (c[4]) {eo[7:6], ee[7:6], gi[7:6], fi[3:2]} =
      {fn[18], fn[16], fn[19], fn[17], 2'b00, i_pad_in[7:6]};
    if (i_gate_reset_select)
      {eo[8], ee[8], gi[8]} = {fn[7], 2'b00};
    check(o_pad_out & ~msk, eo & ~msk);
    check(o_pad_oe_n, ee);
    check({2'b0, fo, o_gpio_in}, {2'b0, fi, gi});
  endtask

  task automatic settle_and_compare;
    repeat (5) @(posedge i_mclk);
    #1;
    compare;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well past the expected run of about 800 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    final_report;
  end

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    void'($urandom(55715));
    {err_total, samples_checked} = 0;
    {i_reset_n, i_ec_wr, i_ec_rd, i_ec_addr, i_ec_wdata} = 27'h0;
    {b, c} = 16'h0;
    stir;
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    settle_and_compare;
    rd(`SEL_B_ADDR, 8'h00);
    rd(`SEL_C_ADDR, 8'h00);
    $display("test reset_defaults done");
    // Upper nibble walks every code pair of pads ten and six
    for (int i = 0; i < 48; i++) begin
      b = {4'(i), 4'($urandom)};
      c = 8'($urandom);
      @(posedge i_mclk);
      stir;
      wr(`SEL_B_ADDR, b);
      rd(`SEL_B_ADDR, b);
      wr(`SEL_C_ADDR, c);
      rd(`SEL_C_ADDR, c);
      rd(16'($urandom) | 16'h8000, 8'h00);
      settle_and_compare;
    end
    $display("test random_selects done");
    // Reset in mid-run with nonzero selects must restore defaults
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    {b, c} = 16'h0;
    settle_and_compare;
    rd(`SEL_B_ADDR, 8'h00);
    rd(`SEL_C_ADDR, 8'h00);
    $display("test midrun_reset done");
    final_report;
  end
endmodule // pin_function_mux_tb
